// File: logic/cic_pkg.sv
// Shared constants and carrier types of the CPU interrupt controller
package cic_pkg;
   // Vector address width and the vector table
   localparam int VEC_W = 12;
   localparam logic [11:0] VEC_TRAP = 12'hffc;
   localparam logic [11:0] VEC_EXT = 12'hffa;
   localparam logic [11:0] VEC_IC2 = 12'hff8;
   localparam logic [11:0] VEC_IC1 = 12'hff6;
   localparam logic [11:0] VEC_TMR = 12'hff4;
   localparam logic [11:0] VEC_SCI = 12'hff2;
   localparam logic [11:0] VEC_CT = 12'hff0;
   // Register byte offsets
   localparam logic [3:0] OFS_EXT_CTRL = 4'h0;
   localparam logic [3:0] OFS_GMASK = 4'h4;
   localparam logic [3:0] OFS_STATUS = 4'h8;
   // Field positions of external_int_status_ctrl
   localparam int EXT_MASK_POS = 7;
   localparam int EXT_SENS_POS = 6;
   localparam int EXT_EDGE_POS = 5;
   localparam int EXT_REQ_POS = 3;
   localparam int EXT_ACK_POS = 1;
   // Field positions of the status word
   localparam int STAT_REQ_POS = 8;
   localparam int STAT_VEC_LSB = 16;
   // Values after reset
   localparam logic RST_EXT_MASK = 1'b0;
   localparam logic RST_SENS = 1'b0;
   localparam logic RST_EDGE = 1'b0;
   localparam logic RST_GLOBAL_MASK = 1'b1;
   localparam logic [11:0] RST_VEC = 12'h000;
   // Clock and input filter timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int SYNC_STAGES = 3;
   localparam int MIN_PULSE_PS = 16000;
   localparam int MIN_PULSE_CYC = (MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Peripheral source counts
   localparam int TMR_SRC = 4;
   localparam int SCI_SRC = 5;
   localparam int CT_SRC = 2;
   localparam int SRC_CNT = 7;

   // Timer source order in the flag and enable vectors
   localparam int TMR_IC2 = 3;
   localparam int TMR_IC1 = 2;
   localparam int TMR_OC = 1;
   localparam int TMR_TOF = 0;

   typedef struct packed {
      logic [TMR_SRC-1:0] tmrFlag;
      logic [TMR_SRC-1:0] tmrEn;
      logic [SCI_SRC-1:0] sciFlag;
      logic [SCI_SRC-1:0] sciEn;
      logic [CT_SRC-1:0] ctFlag;
      logic [CT_SRC-1:0] ctEn;
   } cic_periph_type;

   typedef struct packed {
      logic instrDone;
      logic trapExec;
      logic intTake;
      logic maskSet;
      logic maskClr;
   } cic_seq_type;

   typedef struct packed {
      logic intReq;
      logic [VEC_W-1:0] vector;
      logic globalMask;
   } cic_req_type;

   typedef enum logic [1:0] {
      CIC_IDLE = 2'b00,
      CIC_HW = 2'b01,
      CIC_SW = 2'b11
   } cic_state_type;
endpackage : cic_pkg

// File: logic/cic_pin_sync.sv
// Pin synchroniser with agreement filter and edge detection
`timescale 1ns/1ps
`default_nettype none
module cic_pin_sync (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Pin and polarity
   input wire logic pinIn,
   input wire logic risingSel,
   // Filtered results
   output logic activeLvl,
   output logic activeEdge
);
   import cic_pkg::*;

   logic [SYNC_STAGES-1:0] syncChain_ff;
   logic level_ff;
   logic levelPrev_ff;
   wire agree = syncChain_ff[1] == syncChain_ff[2];
   wire nxt_level = agree ? syncChain_ff[2] : level_ff;

   initial begin
      if (SYNC_STAGES != 3) begin
         $error("cic_pin_sync needs exactly three stages");
      end
   end

   // Idle pin is high; reset level matches so no false edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncChain_ff <= '1;
         level_ff <= 1'b1;
         levelPrev_ff <= 1'b1;
      end else begin
         syncChain_ff <= {syncChain_ff[SYNC_STAGES-2:0], pinIn};
         level_ff <= nxt_level;
         levelPrev_ff <= level_ff;
      end
   end

   // Edge seen once per filtered transition in the direction that risingSel selects
   assign activeLvl = risingSel ? level_ff : ~level_ff;
   assign activeEdge = risingSel ? (level_ff & ~levelPrev_ff)
                                 : (~level_ff & levelPrev_ff);
endmodule : cic_pin_sync
`default_nettype wire

// File: logic/cic_interrupt_control.sv
// Interrupt control block: external pin latch, masks, arbitration, vectors
//
// Notes on behaviour
// - Software trap is taken regardless of global mask, vectors via 0FFC/0FFD.
// - Pending hardware interrupts win over a software trap at the same boundary.
// - Global mask set blocks all hardware interrupts; clear allows enabled ones.
// - External interrupt starts only if latch set and both masks clear.
// - Masks gate after the latch, so requests latch while masked.
// - Qualified pin activity sets latch; latch is examined at instruction end.
// - Pending bit mirrors latch; both clear when the external vector is taken.
// - Ack write of one clears pending once; ack bit reads zero.
// - With level sensitivity, an active pin keeps requesting and ack is void.
// - External mask bit: 1 disables, 0 enables, cleared by reset.
// - Sensitivity bit: 0 edge only, 1 edge and level, cleared by reset.
// - Edge bit: 1 rising, 0 falling, cleared by reset.
// - Reset clears latches and external mask, sets global mask.
// - One pulse latched while masked is serviced once mask clears.
// - Input capture 2 vectors 0FF8, capture 1 vectors 0FF6, flag and enable.
// - Output compare and overflow share 0FF4; software polls flags.
// - Compare and overflow each need flag, enable and clear global mask.
// - Any of five enabled serial flags requests via 0FF2.
// - Either enabled core timer flag requests via 0FF0.
// - Highest vector location wins among pending interrupts.
// - Taking an interrupt sets the global mask, then vector is fetched.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cic_interrupt_control #(
   parameter int VECTOR_WIDTH = 12
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Instruction sequencer
   input wire cic_pkg::cic_seq_type seqIn,
   output cic_pkg::cic_req_type seqOut,
   // Peripheral flags and enables
   input wire cic_pkg::cic_periph_type periphIn,
   // External interrupt pin
   input wire logic extIntPin
);
   import cic_pkg::*;

   initial begin
      if (VECTOR_WIDTH != VEC_W) begin
         $error("cic_interrupt_control supports only a 12-bit vector");
      end
   end

   // ---------------- Register state
   logic extMask_ff;
   logic extSens_ff;
   logic extEdge_ff;
   logic extReq_ff;
   logic globalMask_ff;
   logic intReq_ff;
   logic [VEC_W-1:0] vector_ff;
   cic_state_type state_ff;
   logic waitReq_ff;
   logic [31:0] readData_ff;

   // ---------------- Bus decode
   wire busReq = avs_read | avs_write;
   wire accept = busReq & ~waitReq_ff;
   wire wrAccept = accept & avs_write & avs_byteenable[0];
   wire selExt = avs_address == OFS_EXT_CTRL;
   wire selGmask = avs_address == OFS_GMASK;
   wire selStat = avs_address == OFS_STATUS;
   wire wrExt = wrAccept & selExt;
   wire wrGmask = wrAccept & selGmask;
   wire ackWrite = wrExt & avs_writedata[EXT_ACK_POS];

   // ---------------- External pin
   logic pinActiveLvl;
   logic pinActiveEdge;

   cic_pin_sync cic_pin_sync_inst (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .pinIn(extIntPin),
      .risingSel(extEdge_ff),
      .activeLvl(pinActiveLvl),
      .activeEdge(pinActiveEdge)
   );

   // Level term keeps the latch set while the pin stays active
   wire levelHold = extSens_ff & pinActiveLvl;
   wire extSet = pinActiveEdge | levelHold;
   wire extTaken = (state_ff == CIC_HW) & seqIn.intTake & (vector_ff == VEC_EXT);
   wire extClr = extTaken | ackWrite;

   // ---------------- Source qualification (enables only, masks later)
   wire tmrIc2 = periphIn.tmrFlag[TMR_IC2] & periphIn.tmrEn[TMR_IC2];
   wire tmrIc1 = periphIn.tmrFlag[TMR_IC1] & periphIn.tmrEn[TMR_IC1];
   wire tmrOc = periphIn.tmrFlag[TMR_OC] & periphIn.tmrEn[TMR_OC];
   wire tmrTof = periphIn.tmrFlag[TMR_TOF] & periphIn.tmrEn[TMR_TOF];
   wire tmrShared = tmrOc | tmrTof;
   wire sciAny = |(periphIn.sciFlag & periphIn.sciEn);
   wire ctAny = |(periphIn.ctFlag & periphIn.ctEn);

   // External mask acts after the latch, not before it
   wire extPend = extReq_ff & ~extMask_ff;

   // Source summary, highest vector location first
   wire [SRC_CNT-1:0] srcPend = {extPend, tmrIc2, tmrIc1, tmrShared, sciAny, ctAny, 1'b0};
   wire hwAny = |srcPend;
   wire hwAllowed = hwAny & ~globalMask_ff;

   // Fixed priority by vector location
   logic [VEC_W-1:0] hwVector;
   always_comb begin
      hwVector = VEC_CT;
      if (extPend) begin
         hwVector = VEC_EXT;
      end else if (tmrIc2) begin
         hwVector = VEC_IC2;
      end else if (tmrIc1) begin
         hwVector = VEC_IC1;
      end else if (tmrShared) begin
         hwVector = VEC_TMR;
      end else if (sciAny) begin
         hwVector = VEC_SCI;
      end else begin
         hwVector = VEC_CT;
      end
   end

   // ---------------- Sequencer handshake
   // Hardware is sampled at the same boundary that starts a trap, so it wins
   wire hwStart = seqIn.instrDone & hwAllowed;
   wire swStart = seqIn.trapExec & ~hwStart;

   cic_state_type nxt_state;
   logic nxt_intReq;
   logic [VEC_W-1:0] nxt_vector;
   always_comb begin
      nxt_state = state_ff;
      nxt_intReq = intReq_ff;
      nxt_vector = vector_ff;
      case (state_ff)
         CIC_IDLE: begin
            if (hwStart) begin
               nxt_state = CIC_HW;
               nxt_intReq = 1'b1;
               nxt_vector = hwVector;
            end else if (swStart) begin
               nxt_state = CIC_SW;
               nxt_intReq = 1'b1;
               nxt_vector = VEC_TRAP;
            end
         end
         CIC_HW, CIC_SW: begin
            if (seqIn.intTake) begin
               nxt_state = CIC_IDLE;
               nxt_intReq = 1'b0;
            end
         end
         default: begin
            nxt_state = CIC_IDLE;
            nxt_intReq = 1'b0;
         end
      endcase
   end

   // Taking any vector sets the global mask; a take beats a clear
   wire takeNow = (state_ff != CIC_IDLE) & seqIn.intTake;
   wire maskSetAny = takeNow | seqIn.maskSet | (wrGmask & avs_writedata[0]);
   wire maskClrAny = seqIn.maskClr | (wrGmask & ~avs_writedata[0]);
   wire nxt_globalMask = maskSetAny ? 1'b1 : (maskClrAny ? 1'b0 : globalMask_ff);

   // Set beats clear: an active pin during ack or service keeps the request
   wire nxt_extReq = extSet ? 1'b1 : (extClr ? 1'b0 : extReq_ff);

   // ---------------- Read mux
   wire [7:0] extCtrlView = {extMask_ff, extSens_ff, extEdge_ff, 1'b0, extReq_ff, 3'b000};
   logic [31:0] readMux;
   always_comb begin
      readMux = 32'h0000_0000;
      if (selExt) begin
         readMux = {24'h00_0000, extCtrlView};
      end else if (selGmask) begin
         readMux = {31'h0000_0000, globalMask_ff};
      end else if (selStat) begin
         readMux[SRC_CNT-1:0] = srcPend;
         readMux[STAT_REQ_POS] = intReq_ff;
         readMux[STAT_VEC_LSB +: VEC_W] = vector_ff;
      end
   end

   // ---------------- Bus response: one wait cycle, then accept
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         waitReq_ff <= 1'b1;
         readData_ff <= 32'h0000_0000;
      end else begin
         waitReq_ff <= ~(busReq & waitReq_ff);
         if (busReq & waitReq_ff & avs_read) begin
            readData_ff <= readMux;
         end
      end
   end

   // ---------------- Control bits
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         extMask_ff <= RST_EXT_MASK;
         extSens_ff <= RST_SENS;
         extEdge_ff <= RST_EDGE;
      end else if (wrExt) begin
         extMask_ff <= avs_writedata[EXT_MASK_POS];
         extSens_ff <= avs_writedata[EXT_SENS_POS];
         extEdge_ff <= avs_writedata[EXT_EDGE_POS];
      end
   end

   // ---------------- Latch, global mask and request
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         extReq_ff <= 1'b0;
         globalMask_ff <= RST_GLOBAL_MASK;
      end else begin
         extReq_ff <= nxt_extReq;
         globalMask_ff <= nxt_globalMask;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= CIC_IDLE;
         intReq_ff <= 1'b0;
         vector_ff <= RST_VEC;
      end else begin
         state_ff <= nxt_state;
         intReq_ff <= nxt_intReq;
         vector_ff <= nxt_vector;
      end
   end

   // Outputs straight from flip-flops
   assign avs_waitrequest = waitReq_ff;
   assign avs_readdata = readData_ff;
   // One driver for the whole struct variable
   assign seqOut = '{intReq: intReq_ff, vector: vector_ff, globalMask: globalMask_ff};
endmodule : cic_interrupt_control
`default_nettype wire

// File: verif/cic_interrupt_control_assertions.sv
// Port checks of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module cic_interrupt_control_assertions (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Bus
   input wire logic [3:0] avs_address,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Sequencer, sources, pin
   input wire cic_pkg::cic_seq_type seqIn,
   input wire cic_pkg::cic_req_type seqOut,
   input wire cic_pkg::cic_periph_type periphIn,
   input wire logic extIntPin
);
   import cic_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire logic busReq = avs_read | avs_write;
   wire logic hwOk = seqIn.instrDone && !seqOut.intReq && !seqOut.globalMask;
   bus_answer_a: assert property (busReq && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   ack_zero_a: assert property (
      !avs_waitrequest && avs_read && avs_address == OFS_EXT_CTRL
      |-> !avs_readdata[EXT_ACK_POS] && avs_readdata[31:8] == 24'h000000)
      else $error("ack bit read as one");
   trap_vector_a: assert property (
      seqIn.trapExec && !seqIn.instrDone && !seqOut.intReq
      |=> seqOut.intReq && seqOut.vector == VEC_TRAP)
      else $error("trap not requested");
   mask_blocks_a: assert property (
      seqIn.instrDone && seqOut.globalMask && !seqIn.trapExec
      && !seqOut.intReq |=> !seqOut.intReq)
      else $error("request while masked");
   take_mask_a: assert property (seqIn.intTake |=> !seqOut.intReq && seqOut.globalMask)
      else $error("take did not end request");
   req_hold_a: assert property (
      seqOut.intReq && !seqIn.intTake
      |=> seqOut.intReq && $stable(seqOut.vector))
      else $error("request not held");
   cap_two_a: assert property (
      hwOk && periphIn.tmrFlag[TMR_IC2] && periphIn.tmrEn[TMR_IC2]
      |=> seqOut.intReq && seqOut.vector >= VEC_IC2)
      else $error("capture two lost priority");
   serial_req_a: assert property (
      hwOk && |(periphIn.sciFlag & periphIn.sciEn)
      |=> seqOut.intReq && seqOut.vector >= VEC_SCI)
      else $error("serial request missing");
   cover property (seqIn.intTake && seqOut.vector == VEC_EXT);
   cover property (seqIn.intTake && seqOut.vector == VEC_CT);
   cover property (seqIn.intTake && seqOut.vector == VEC_TRAP);
endmodule : cic_interrupt_control_assertions
`default_nettype wire

// File: verif/cic_seq_model.sv
// Sequencer model: command pulses and paced vector take
`timescale 1ns/1ps
`default_nettype none
module cic_seq_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Commands {clear mask, trap, done} and pace
   input wire logic [2:0] cmd,
   input wire logic slow,
   // Controller side
   input wire cic_pkg::cic_req_type seqOut,
   output cic_pkg::cic_seq_type seqIn
);
   import cic_pkg::*;
   logic [2:0] waitCnt_ff;
   // Take only while a request stands, never twice for one request
   wire logic takeNow = seqOut.intReq && !seqIn.intTake && waitCnt_ff == (slow ? 3'h4 : 3'h0);
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         seqIn <= '0;
         waitCnt_ff <= 3'h0;
      end else begin
         seqIn <= '{cmd[0], cmd[1], takeNow, 1'b0, cmd[2]};
         waitCnt_ff <= (seqOut.intReq && !takeNow) ? waitCnt_ff + 3'h1 : 3'h0;
      end
   end
endmodule : cic_seq_model
`default_nettype wire

// File: verif/cpu_interrupt_control_bench.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_control_bench;
   import cic_pkg::*;
   logic sys_clk, nrst, avs_read, avs_write, slow, extIntPin, avs_waitrequest;
   logic [2:0] cmd;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, r;
   cic_seq_type seqIn;
   cic_req_type seqOut;
   cic_periph_type periphIn, p;
   int fail_count = 0;
   int compares = 0;
   logic [31:0] rdQ[$];
   logic [11:0] vecQ[$];
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   cic_interrupt_control cic_interrupt_control_inst (.sys_clk, .nrst, .avs_address,
      .avs_byteenable(4'hf), .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .seqIn, .seqOut, .periphIn, .extIntPin);
   cic_seq_model cic_seq_model_inst (.sys_clk, .nrst, .cmd, .slow, .seqOut, .seqIn);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      // Idle edge so a following call never reassigns in this time step
      @(posedge sys_clk);
   endtask : acc
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      rdQ.push_back(e);
      acc(1'b0, a, 32'h0);
   endtask : rd
   // Bit 12 of v says whether a request is due
   task automatic go(input logic [2:0] c, input logic [12:0] v);
      if (v[12]) vecQ.push_back(v[11:0]);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 3'h0;
      tick(3);
      for (int i = 0; i < 20 && seqOut.intReq !== 1'b0; i++) @(posedge sys_clk);
   endtask : go
   task automatic pin(input logic v);
      extIntPin <= v;
      tick(6);
   endtask : pin
   function automatic logic [12:0] pick(input cic_periph_type q);
      logic [3:0] t;
      t = q.tmrFlag & q.tmrEn;
      if (t[TMR_IC2]) return {1'b1, VEC_IC2};
      if (t[TMR_IC1]) return {1'b1, VEC_IC1};
      if (|t[1:0]) return {1'b1, VEC_TMR};
      if (|(q.sciFlag & q.sciEn)) return {1'b1, VEC_SCI};
      if (|(q.ctFlag & q.ctEn)) return {1'b1, VEC_CT};
      return 13'h0;
   endfunction : pick
   // Results are compared in arrival order against the notes
   always @(posedge sys_clk) begin
      if (avs_read && avs_waitrequest === 1'b0) begin
         if (rdQ.size() == 0) chk(32'h1, 32'h0);
         else chk(avs_readdata, rdQ.pop_front());
      end
      if (nrst && $rose(seqOut.intReq)) begin
         if (vecQ.size() == 0) chk(32'h1, 32'h0);
         else chk({20'h0, seqOut.vector}, {20'h0, vecQ.pop_front()});
      end
   end
   task automatic finish_test;
      chk(rdQ.size() + vecQ.size(), 32'h0);
      $display("Compares %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   initial begin
      #200000;
      fail_count++;
      finish_test;
   end
   initial begin
      {nrst, avs_read, avs_write, slow, cmd, avs_address} = '0;
      {avs_writedata, periphIn} = '0;
      extIntPin = 1'b1;
      r = $urandom(96);
      tick(3);
      nrst <= 1'b1;
      tick(1);
      rd(OFS_EXT_CTRL, 32'h0);
      rd(OFS_GMASK, 32'h1);
      rd(4'hc, 32'h0);
      acc(1'b1, OFS_EXT_CTRL, 32'hc2);
      rd(OFS_EXT_CTRL, 32'hc0);
      acc(1'b1, OFS_EXT_CTRL, 32'h22);
      rd(OFS_EXT_CTRL, 32'h20);
      acc(1'b1, OFS_EXT_CTRL, 32'h0);
      $display("Test registers done");
      pin(1'b0);
      pin(1'b1);
      rd(OFS_EXT_CTRL, 32'h08);
      acc(1'b1, OFS_GMASK, 32'h0);
      go(3'h1, {1'b1, VEC_EXT});
      rd(OFS_EXT_CTRL, 32'h0);
      rd(OFS_GMASK, 32'h1);
      go(3'h4, 13'h0);
      go(3'h1, 13'h0);
      acc(1'b1, OFS_GMASK, 32'h1);
      pin(1'b0);
      pin(1'b1);
      acc(1'b1, OFS_EXT_CTRL, 32'h02);
      rd(OFS_EXT_CTRL, 32'h0);
      pin(1'b0);
      pin(1'b1);
      rd(OFS_EXT_CTRL, 32'h08);
      $display("Test pin edge done");
      acc(1'b1, OFS_EXT_CTRL, 32'h42);
      pin(1'b0);
      go(3'h4, 13'h0);
      go(3'h1, {1'b1, VEC_EXT});
      go(3'h4, 13'h0);
      go(3'h1, {1'b1, VEC_EXT});
      acc(1'b1, OFS_EXT_CTRL, 32'h42);
      rd(OFS_EXT_CTRL, 32'h48);
      pin(1'b1);
      acc(1'b1, OFS_EXT_CTRL, 32'h42);
      rd(OFS_EXT_CTRL, 32'h40);
      acc(1'b1, OFS_EXT_CTRL, 32'ha2);
      pin(1'b0);
      rd(OFS_EXT_CTRL, 32'ha0);
      pin(1'b1);
      rd(OFS_EXT_CTRL, 32'ha8);
      go(3'h4, 13'h0);
      go(3'h1, 13'h0);
      acc(1'b1, OFS_EXT_CTRL, 32'h02);
      acc(1'b1, OFS_GMASK, 32'h1);
      $display("Test level and masks done");
      for (int i = 0; i < 40; i++) begin
         r = $urandom;
         p = r[21:0];
         if (i % 5 > 0) p.tmrEn[TMR_IC2] = 1'b0;
         if (i % 5 > 1) p.tmrEn[TMR_IC1] = 1'b0;
         if (i % 5 > 2) p.tmrEn[1:0] = 2'b00;
         if (i % 5 > 3) p.sciEn = '0;
         periphIn <= p;
         slow <= r[31];
         go(3'h1, 13'h0);
         go(3'h4, 13'h0);
         go(3'h1, pick(p));
         if (!pick(p)) acc(1'b1, OFS_GMASK, 32'h1);
      end
      $display("Test sources done");
      go(3'h2, {1'b1, VEC_TRAP});
      periphIn <= 22'h5;
      go(3'h4, 13'h0);
      go(3'h3, {1'b1, VEC_CT});
      $display("Test trap done");
      finish_test;
   end
endmodule : cpu_interrupt_control_bench
bind cic_interrupt_control cic_interrupt_control_assertions cic_interrupt_control_assertions_inst (
   .sys_clk, .nrst, .avs_address, .avs_byteenable, .avs_read, .avs_write, .avs_writedata,
   .avs_readdata, .avs_waitrequest, .seqIn, .seqOut, .periphIn, .extIntPin);
`default_nettype wire
